//--- design/gric_top.sv
// global reset, power-down, gpio and interrupt control for 16 ports
// assumes a host command port of one byte write per cycle, sync inputs
//
// Notes on behaviour
// [RULE1] hardware reset pin low resets all framers, line units, testers
// [RULE2] host rewrites whole register space, reserved included, after any reset
// [RULE3] test-port reset pin resets only the test port
// [RULE4] write to either global soft reset register resets all datapaths
// [RULE5] bit 1 of rx/tx master mode resets rx/tx framer
// [RULE6] rx link bit 6, tx link bit 5 reset link controllers
// [RULE7] bit 2 of elastic control resets rx/tx elastic store
// [RULE8] bit 7 of bitcode control resets rx bitcode controller
// [RULE9] loop-up, loop-down or spare code write restarts integration period
// [RULE10] tx power-down disables transmitter and floats its line outputs
// [RULE11] rx power-down bit powers down that port's receiver
// [RULE12] tx enable clear floats line outputs, unit stays powered
// [RULE13] host resets, reads identity, writes clock control, waits 300ns
// [RULE14] host writes zero to remaining register space of each port
// [RULE15] host sets mode, framer enable, control, then init done
// [RULE16] host picks line standard, build-out, then sets tx enable
// [RULE17] sixteen gpio pins in two groups of eight, one function each
// [RULE18] global info shows pending ports; port info points to sources
// [RULE19] info bits are live and drop once unmasked status clears
// [RULE20] latched status holds until host writes one to it
// [RULE21] mask keeps status off info and interrupt, not off latch
// [RULE22] host combines status with mask to skip masked bits
// [RULE23] interrupt asserted while any unmasked latched status remains
`timescale 1ns/1ns
`default_nettype none
module gric_top #(
    parameter int PORTS = gric_pkg::NUM_PORTS
) (
    input wire logic ref_clk, // 50 MHz system clock
    input wire logic rst, // sync reset, high
    input wire logic hw_reset_n, // hardware reset pin, low
    input wire logic test_port_reset_n, // test-port reset pin, low
    input wire gric_pkg::gric_write_t host_wr, // host register write
    input wire logic [PORTS*8-1:0] tx_event, // tx status events
    input wire logic [PORTS*8-1:0] rx_event, // rx status events
    input wire logic [PORTS*8-1:0] line_event, // line status events
    input wire logic [PORTS*8-1:0] test_event, // tester status events
    input wire logic [2*8-1:0] gpio_alarm, // alarm per group source
    input wire logic [PORTS-1:0] gpio_in, // gpio pin inputs
    output logic [PORTS-1:0] dp_reset_r, // framer/line/tester reset
    output logic test_port_reset_r, // test port reset
    output logic [PORTS-1:0] rx_framer_rst_r, // rx framer reset pulse
    output logic [PORTS-1:0] tx_framer_rst_r, // tx framer reset pulse
    output logic [PORTS-1:0] rx_link_rst_r, // rx link ctrl reset pulse
    output logic [PORTS-1:0] tx_link_rst_r, // tx link ctrl reset pulse
    output logic [PORTS-1:0] rx_es_rst_r, // rx elastic reset pulse
    output logic [PORTS-1:0] tx_es_rst_r, // tx elastic reset pulse
    output logic [PORTS-1:0] bitcode_rst_r, // rx bitcode reset pulse
    output logic [PORTS-1:0] integ_restart_r, // code integration restart
    output logic [PORTS-1:0] tx_power_r, // transmitter powered
    output logic [PORTS-1:0] rx_power_r, // receiver powered
    output logic [PORTS-1:0] line_tx_oe_n_r, // tip/ring enable, low drives
    output logic [PORTS-1:0] gpio_out_r, // gpio output value
    output logic [PORTS-1:0] gpio_oe_n_r, // gpio enable, low drives
    output logic [PORTS-1:0] gfr_info_r, // global framer info
    output logic [PORTS-1:0] gline_info_r, // global line info
    output logic [PORTS-1:0] gtest_info_r, // global tester info
    output logic [PORTS-1:0] tx_irq_info_r, // per-port tx info
    output logic [PORTS-1:0] rx_irq_info_r, // per-port rx info
    output logic irq_n_r // interrupt out, low
);
    // ------------------------------------------------------------
    // host write decode
    // ------------------------------------------------------------
    function automatic logic [PORTS-1:0] port_hit(input gric_pkg::gric_write_t w,
                                                   input logic [3:0] sel);
        logic [PORTS-1:0] v;
        v = '0;
        if (w.wr && w.reg_sel == sel)
            v[w.port] = 1'b1;
        return v;
    endfunction

    logic soft_rst;
    logic [PORTS-1:0] hit_rxmm, hit_txmm, hit_rxl, hit_txl, hit_rxes, hit_txes;
    logic [PORTS-1:0] hit_boc, hit_code, hit_lm;
    assign hit_rxmm = port_hit(host_wr, gric_pkg::SEL_RX_MM);
    assign hit_txmm = port_hit(host_wr, gric_pkg::SEL_TX_MM);
    assign hit_rxl = port_hit(host_wr, gric_pkg::SEL_RX_LINK);
    assign hit_txl = port_hit(host_wr, gric_pkg::SEL_TX_LINK);
    assign hit_rxes = port_hit(host_wr, gric_pkg::SEL_RX_ES);
    assign hit_txes = port_hit(host_wr, gric_pkg::SEL_TX_ES);
    assign hit_boc = port_hit(host_wr, gric_pkg::SEL_BITCODE);
    assign hit_lm = port_hit(host_wr, gric_pkg::SEL_LINE_MAINT);
    // any of the three code detect registers restarts integration
    assign hit_code = port_hit(host_wr, gric_pkg::SEL_LOOPUP)
        | port_hit(host_wr, gric_pkg::SEL_LOOPDN)
        | port_hit(host_wr, gric_pkg::SEL_SPARE); // see [RULE9]
    // either global register, any data
    assign soft_rst = host_wr.wr && (host_wr.reg_sel == gric_pkg::SEL_SOFT_RST_1
        || host_wr.reg_sel == gric_pkg::SEL_SOFT_RST_2); // see [RULE4]

    // ------------------------------------------------------------
    // reset distribution
    // ------------------------------------------------------------
    logic [PORTS-1:0] dp_reset_nxt, rxf_nxt, txf_nxt, rxl_nxt, txl_nxt;
    logic [PORTS-1:0] rxes_nxt, txes_nxt, boc_nxt, integ_nxt;
    logic test_rst_nxt;

    // reset pulses last one cycle per write; hold is up to the datapath
    always_comb
    begin
        dp_reset_nxt = {PORTS{!hw_reset_n || soft_rst}}; // see [RULE1] [RULE4]
        test_rst_nxt = !test_port_reset_n; // see [RULE3]
        rxf_nxt = hit_rxmm & {PORTS{host_wr.data[gric_pkg::RXMM_RST_BIT]}}; // see [RULE5]
        txf_nxt = hit_txmm & {PORTS{host_wr.data[gric_pkg::TXMM_RST_BIT]}}; // see [RULE5]
        rxl_nxt = hit_rxl & {PORTS{host_wr.data[gric_pkg::RXLINK_RST_BIT]}}; // see [RULE6]
        txl_nxt = hit_txl & {PORTS{host_wr.data[gric_pkg::TXLINK_RST_BIT]}}; // see [RULE6]
        rxes_nxt = hit_rxes & {PORTS{host_wr.data[gric_pkg::ELASTIC_RST_BIT]}}; // see [RULE7]
        txes_nxt = hit_txes & {PORTS{host_wr.data[gric_pkg::ELASTIC_RST_BIT]}}; // see [RULE7]
        boc_nxt = hit_boc & {PORTS{host_wr.data[gric_pkg::BITCODE_RST_BIT]}}; // see [RULE8]
        integ_nxt = hit_code;
    end

    // test port reset ignores rst so other resets never touch it
    always_ff @(posedge ref_clk)
    begin
        test_port_reset_r <= test_rst_nxt; // see [RULE3]
        if (rst)
        begin
            dp_reset_r <= gric_pkg::PORT_ONES;
            rx_framer_rst_r <= gric_pkg::PORT_ZERO;
            tx_framer_rst_r <= gric_pkg::PORT_ZERO;
            rx_link_rst_r <= gric_pkg::PORT_ZERO;
            tx_link_rst_r <= gric_pkg::PORT_ZERO;
            rx_es_rst_r <= gric_pkg::PORT_ZERO;
            tx_es_rst_r <= gric_pkg::PORT_ZERO;
            bitcode_rst_r <= gric_pkg::PORT_ZERO;
            integ_restart_r <= gric_pkg::PORT_ZERO;
        end
        else
        begin
            dp_reset_r <= dp_reset_nxt;
            rx_framer_rst_r <= rxf_nxt;
            tx_framer_rst_r <= txf_nxt;
            rx_link_rst_r <= rxl_nxt;
            tx_link_rst_r <= txl_nxt;
            rx_es_rst_r <= rxes_nxt;
            tx_es_rst_r <= txes_nxt;
            bitcode_rst_r <= boc_nxt;
            integ_restart_r <= integ_nxt;
        end
    end

    // ------------------------------------------------------------
    // line maintenance: power-down and transmit enable
    // ------------------------------------------------------------
    logic [PORTS-1:0] txpd_r, rxpd_r, txen_r, txpd_nxt, rxpd_nxt, txen_nxt;
    logic [PORTS-1:0] txpow_nxt, rxpow_nxt, oe_n_nxt;

    // outputs float on tx power-down or on a cleared enable
    always_comb
    begin
        txpd_nxt = txpd_r;
        rxpd_nxt = rxpd_r;
        txen_nxt = txen_r;
        for (int p = 0; p < PORTS; p++)
        begin
            if (hit_lm[p])
            begin
                txpd_nxt[p] = host_wr.data[gric_pkg::TXPD_BIT];
                rxpd_nxt[p] = host_wr.data[gric_pkg::RXPD_BIT];
                txen_nxt[p] = host_wr.data[gric_pkg::TXOE_BIT];
            end
        end
        txpow_nxt = ~txpd_nxt; // see [RULE10]
        rxpow_nxt = ~rxpd_nxt; // see [RULE11]
        oe_n_nxt = txpd_nxt | ~txen_nxt; // see [RULE10] [RULE12]
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            txpd_r <= gric_pkg::PORT_ZERO;
            rxpd_r <= gric_pkg::PORT_ZERO;
            txen_r <= gric_pkg::PORT_ZERO;
            tx_power_r <= gric_pkg::PORT_ONES;
            rx_power_r <= gric_pkg::PORT_ONES;
            line_tx_oe_n_r <= gric_pkg::PORT_ONES;
        end
        else
        begin
            txpd_r <= txpd_nxt;
            rxpd_r <= rxpd_nxt;
            txen_r <= txen_nxt;
            tx_power_r <= txpow_nxt;
            rx_power_r <= rxpow_nxt;
            line_tx_oe_n_r <= oe_n_nxt;
        end
    end

    // ------------------------------------------------------------
    // general-purpose pins: two groups sharing one function each
    // ------------------------------------------------------------
    logic [7:0] gsel_r, gsel_nxt;
    logic [PORTS-1:0] gpio_nxt, goe_nxt;

    // low nibble picks group 1 source, high nibble group 2; 0 means input
    always_comb
    begin
        gsel_nxt = gsel_r;
        if (host_wr.wr && host_wr.reg_sel == gric_pkg::SEL_GPIO_SEL)
            gsel_nxt = host_wr.data;
        for (int p = 0; p < PORTS; p++)
        begin
            logic [3:0] s;
            s = (p < gric_pkg::GROUP_SIZE) ? gsel_r[3:0] : gsel_r[7:4];
            goe_nxt[p] = (s == 4'h0); // see [RULE17]
            gpio_nxt[p] = (s == 4'h0) ? 1'b0
                : gpio_alarm[(p / gric_pkg::GROUP_SIZE)*8 + int'(s[2:0])]; // see [RULE17]
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            gsel_r <= gric_pkg::WORD_ZERO;
            gpio_out_r <= gric_pkg::PORT_ZERO;
            gpio_oe_n_r <= gric_pkg::PORT_ONES;
        end
        else
        begin
            gsel_r <= gsel_nxt;
            gpio_out_r <= gpio_nxt;
            gpio_oe_n_r <= goe_nxt;
        end
    end

    // ------------------------------------------------------------
    // interrupt tree
    // ------------------------------------------------------------
    logic [PORTS-1:0] pend [gric_pkg::NUM_SRC];
    logic [PORTS*8-1:0] stat [gric_pkg::NUM_SRC];
    logic [PORTS*8-1:0] ev [gric_pkg::NUM_SRC];
    assign ev[0] = tx_event;
    assign ev[1] = rx_event;
    assign ev[2] = line_event;
    assign ev[3] = test_event;

    // clear and mask data byte: bits 7:6 pick which status group
    for (genvar g = 0; g < gric_pkg::NUM_SRC; g++)
    begin : g_bank
        gric_status_bank #(.PORTS(PORTS), .W(8)) u_bank (
            .ref_clk(ref_clk),
            .rst(rst),
            .event_in(ev[g]),
            .clr_we(host_wr.wr && host_wr.reg_sel == gric_pkg::SEL_STAT_CLR
                && host_wr.data[7:6] == 2'(g)), // see [RULE20]
            .mask_we(host_wr.wr && host_wr.reg_sel == gric_pkg::SEL_MASK
                && host_wr.data[7:6] == 2'(g)), // see [RULE21]
            .port_sel(host_wr.port),
            .wdata(host_wr.data),
            .status_r(stat[g]),
            .pend_r(pend[g])
        );
    end

    logic irq_nxt;
    // pend is already one cycle behind; info registers add one more
    always_comb
    begin
        irq_nxt = |(pend[0] | pend[1] | pend[2] | pend[3]); // see [RULE23]
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            tx_irq_info_r <= gric_pkg::PORT_ZERO;
            rx_irq_info_r <= gric_pkg::PORT_ZERO;
            gfr_info_r <= gric_pkg::PORT_ZERO;
            gline_info_r <= gric_pkg::PORT_ZERO;
            gtest_info_r <= gric_pkg::PORT_ZERO;
            irq_n_r <= 1'b1;
        end
        else
        begin
            tx_irq_info_r <= pend[gric_pkg::SRC_TX]; // see [RULE18] [RULE19]
            rx_irq_info_r <= pend[gric_pkg::SRC_RX]; // see [RULE18] [RULE19]
            gfr_info_r <= pend[gric_pkg::SRC_TX] | pend[gric_pkg::SRC_RX]; // see [RULE18]
            gline_info_r <= pend[gric_pkg::SRC_LINE]; // see [RULE21]
            gtest_info_r <= pend[gric_pkg::SRC_TEST];
            irq_n_r <= ~irq_nxt; // see [RULE23]
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_HW_RESET: assert property (@(posedge ref_clk) disable iff (rst)
        !hw_reset_n |=> dp_reset_r == gric_pkg::PORT_ONES) // see [RULE1]
        else $error("hardware reset not distributed");
    AST_TEST_RESET: assert property (@(posedge ref_clk)
        hw_reset_n && !soft_rst |=> test_port_reset_r == $past(!test_port_reset_n)) // see [RULE3]
        else $error("test port reset wrong");
    AST_SOFT_RESET: assert property (@(posedge ref_clk) disable iff (rst)
        soft_rst |=> &dp_reset_r) // see [RULE4]
        else $error("soft reset missed");
    AST_FRAMER_RST: assert property (@(posedge ref_clk) disable iff (rst)
        host_wr.wr && host_wr.reg_sel == gric_pkg::SEL_RX_MM && host_wr.data[gric_pkg::RXMM_RST_BIT]
        |=> rx_framer_rst_r[$past(host_wr.port)] ##1 !rx_framer_rst_r[$past(host_wr.port, 2)]) // see [RULE5]
        else $error("rx framer reset pulse wrong");
    AST_INTEG: assert property (@(posedge ref_clk) disable iff (rst)
        host_wr.wr && host_wr.reg_sel == gric_pkg::SEL_SPARE
        |=> integ_restart_r[$past(host_wr.port)]) // see [RULE9]
        else $error("integration restart missed");
    AST_TXPD: assert property (@(posedge ref_clk) disable iff (rst)
        &(tx_power_r | line_tx_oe_n_r)) // see [RULE10]
        else $error("driver on while powered down");
    AST_RXPD: assert property (@(posedge ref_clk) disable iff (rst)
        |hit_lm |=> rx_power_r[$past(host_wr.port)] != $past(host_wr.data[gric_pkg::RXPD_BIT]))
        // see [RULE11]
        else $error("rx power-down not applied");
    AST_IRQ: assert property (@(posedge ref_clk) disable iff (rst)
        |(pend[0] | pend[1] | pend[2] | pend[3]) |=> !irq_n_r) // see [RULE23]
        else $error("interrupt not raised");
endmodule
`default_nettype wire

//--- design/gric_pkg.sv
// package for the global reset and interrupt control block
// assumes a single 50 MHz ref_clk domain and 16 ports
package gric_pkg;
    localparam int NUM_PORTS = 16;
    localparam int GROUP_SIZE = 8;
    localparam int SRC_W = 8;
    localparam int NUM_SRC = 4;
    // bit positions of the per-function software reset bits
    localparam int RXMM_RST_BIT = 1;
    localparam int TXMM_RST_BIT = 1;
    localparam int RXLINK_RST_BIT = 6;
    localparam int TXLINK_RST_BIT = 5;
    localparam int ELASTIC_RST_BIT = 2;
    localparam int BITCODE_RST_BIT = 7;
    // latched status groups per port
    localparam logic [1:0] SRC_TX = 2'h0;
    localparam logic [1:0] SRC_RX = 2'h1;
    localparam logic [1:0] SRC_LINE = 2'h2;
    localparam logic [1:0] SRC_TEST = 2'h3;
    localparam logic [SRC_W-1:0] STATUS_RST = 8'h00;
    localparam logic [SRC_W-1:0] MASK_RST = 8'hFF;
    localparam logic [NUM_PORTS-1:0] PORT_ZERO = 16'h0000;
    localparam logic [NUM_PORTS-1:0] PORT_ONES = 16'hFFFF;
    localparam logic [7:0] WORD_ZERO = 8'h00;

    // one host write to a byte register of one port
    typedef struct packed {
        logic wr;
        logic [3:0] port;
        logic [3:0] reg_sel;
        logic [7:0] data;
    } gric_write_t;

    // register selects on the host command port
    localparam logic [3:0] SEL_SOFT_RST_1 = 4'h0;
    localparam logic [3:0] SEL_SOFT_RST_2 = 4'h1;
    localparam logic [3:0] SEL_RX_MM = 4'h2;
    localparam logic [3:0] SEL_TX_MM = 4'h3;
    localparam logic [3:0] SEL_RX_LINK = 4'h4;
    localparam logic [3:0] SEL_TX_LINK = 4'h5;
    localparam logic [3:0] SEL_RX_ES = 4'h6;
    localparam logic [3:0] SEL_TX_ES = 4'h7;
    localparam logic [3:0] SEL_BITCODE = 4'h8;
    localparam logic [3:0] SEL_LOOPUP = 4'h9;
    localparam logic [3:0] SEL_LOOPDN = 4'hA;
    localparam logic [3:0] SEL_SPARE = 4'hB;
    localparam logic [3:0] SEL_LINE_MAINT = 4'hC;
    localparam logic [3:0] SEL_STAT_CLR = 4'hD;
    localparam logic [3:0] SEL_MASK = 4'hE;
    localparam logic [3:0] SEL_GPIO_SEL = 4'hF;
    // line maintenance bit positions
    localparam int TXPD_BIT = 0;
    localparam int RXPD_BIT = 1;
    localparam int TXOE_BIT = 2;
endpackage

//--- design/gric_status_bank.sv
// one latched status group for all ports, with mask and w1c clear
// assumes events are single-cycle pulses on ref_clk
`timescale 1ns/1ns
`default_nettype none
module gric_status_bank #(
    parameter int PORTS = 16,
    parameter int W = 8
) (
    input wire logic ref_clk, // system clock
    input wire logic rst, // sync reset, high
    input wire logic [PORTS*W-1:0] event_in, // raw event pulses
    input wire logic clr_we, // clear strobe
    input wire logic mask_we, // mask write strobe
    input wire logic [3:0] port_sel, // port for strobes
    input wire logic [W-1:0] wdata, // write data
    output logic [PORTS*W-1:0] status_r, // latched status
    output logic [PORTS-1:0] pend_r // unmasked pending per port
);
    logic [PORTS*W-1:0] mask_r;
    logic [PORTS*W-1:0] status_nxt;
    logic [PORTS*W-1:0] mask_nxt;
    logic [PORTS-1:0] pend_nxt;

    // set wins over the w1c clear; mask never blocks the latch
    always_comb
    begin
        status_nxt = status_r;
        mask_nxt = mask_r;
        for (int p = 0; p < PORTS; p++)
        begin
            if (clr_we && port_sel == p[3:0])
                status_nxt[p*W +: W] = status_r[p*W +: W] & ~wdata; // see [RULE20]
            if (mask_we && port_sel == p[3:0])
                mask_nxt[p*W +: W] = wdata;
            status_nxt[p*W +: W] = status_nxt[p*W +: W] | event_in[p*W +: W]; // see [RULE21]
            pend_nxt[p] = |(status_nxt[p*W +: W] & ~mask_nxt[p*W +: W]); // see [RULE19]
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            status_r <= '0;
            mask_r <= '1;
            pend_r <= '0;
        end
        else
        begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            pend_r <= pend_nxt;
        end
    end
endmodule
`default_nettype wire

//--- sim/gric_host_model.sv
// host processor model on the register write port
// assumes ref_clk from the bench; it changes host_wr on falling edges only
`timescale 1ns/1ns
`default_nettype none
module gric_host_model (
    input wire logic ref_clk, // system clock
    output var gric_pkg::gric_write_t host_wr // write command
);
    // ---------------------------------------------
    // write cycles
    // ---------------------------------------------
    initial host_wr = '0;

    // one write, taken at the rising edge between the two falling edges
    task automatic write_reg(input logic [3:0] port, input logic [3:0] sel,
                             input logic [7:0] data);
        @(negedge ref_clk);
        host_wr = '{wr: 1'b1, port: port, reg_sel: sel, data: data};
        @(negedge ref_clk);
        // idle fields flipped, so stale values are never mistaken for a write
        host_wr = '{wr: 1'b0, port: ~port, reg_sel: ~sel, data: ~data};
    endtask

    // write zero to selects 2 to 15 of one port after reset, soft resets left alone
    task automatic zero_port(input logic [3:0] port);
        for (int s = 2; s < 16; s++)
            write_reg(port, 4'(s), 8'h00);
    endtask

    // clear only serviced, unmasked conditions
    task automatic clear_status(input logic [3:0] port, input logic [7:0] stat,
                                input logic [7:0] mask);
        write_reg(port, gric_pkg::SEL_STAT_CLR, stat & ~mask);
    endtask

    // line driver on once the line is set up
    task automatic enable_line(input logic [3:0] port);
        write_reg(port, gric_pkg::SEL_LINE_MAINT, 8'h04);
    endtask
endmodule
`default_nettype wire

//--- sim/global_reset_interrupt_control_tb_top.sv
// self-checking bench for the global reset and interrupt control block
// assumes gric_pkg and the host model; inputs change on falling edges
`timescale 1ns/1ns
`default_nettype none
module global_reset_interrupt_control_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hw_reset_n = 1'b1;
    logic test_port_reset_n = 1'b1;
    gric_pkg::gric_write_t host_wr;
    logic [127:0] tx_event = '0;
    logic [127:0] rx_event = '0;
    logic [127:0] line_event = '0;
    logic [15:0] gpio_alarm = 16'h0000;
    logic [15:0] dp_reset_r, rx_framer_rst_r, tx_framer_rst_r, rx_link_rst_r;
    logic [15:0] tx_link_rst_r, rx_es_rst_r, tx_es_rst_r, bitcode_rst_r;
    logic [15:0] integ_restart_r, tx_power_r, rx_power_r, line_tx_oe_n_r;
    logic [15:0] gpio_out_r, gpio_oe_n_r, gfr_info_r, tx_irq_info_r;
    logic [15:0] rx_irq_info_r, gline_info_r;
    logic test_port_reset_r, irq_n_r;
    logic [7:0] d;
    int err_count = 0;
    int num_checks = 0;
    logic [3:0] sel_tab [10] = '{gric_pkg::SEL_RX_MM, gric_pkg::SEL_TX_MM,
        gric_pkg::SEL_RX_LINK, gric_pkg::SEL_TX_LINK, gric_pkg::SEL_RX_ES,
        gric_pkg::SEL_TX_ES, gric_pkg::SEL_BITCODE, gric_pkg::SEL_LOOPUP,
        gric_pkg::SEL_LOOPDN, gric_pkg::SEL_SPARE};
    int bit_tab [7] = '{1, 1, 6, 5, 2, 2, 7};

    // ---------------------------------------------
    // clock, dut and host
    // ---------------------------------------------
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end

    gric_top gric_top_inst (.ref_clk(ref_clk), .rst(rst), .hw_reset_n(hw_reset_n),
        .test_port_reset_n(test_port_reset_n), .host_wr(host_wr), .tx_event(tx_event),
        .rx_event(rx_event), .line_event(line_event), .test_event(128'h0),
        .gpio_alarm(gpio_alarm), .gpio_in(16'h0000), .dp_reset_r(dp_reset_r),
        .test_port_reset_r(test_port_reset_r), .rx_framer_rst_r(rx_framer_rst_r),
        .tx_framer_rst_r(tx_framer_rst_r), .rx_link_rst_r(rx_link_rst_r),
        .tx_link_rst_r(tx_link_rst_r), .rx_es_rst_r(rx_es_rst_r),
        .tx_es_rst_r(tx_es_rst_r), .bitcode_rst_r(bitcode_rst_r),
        .integ_restart_r(integ_restart_r), .tx_power_r(tx_power_r),
        .rx_power_r(rx_power_r), .line_tx_oe_n_r(line_tx_oe_n_r),
        .gpio_out_r(gpio_out_r), .gpio_oe_n_r(gpio_oe_n_r), .gfr_info_r(gfr_info_r),
        .gline_info_r(gline_info_r), .gtest_info_r(), .tx_irq_info_r(tx_irq_info_r),
        .rx_irq_info_r(rx_irq_info_r), .irq_n_r(irq_n_r));

    gric_host_model gric_host_model_inst (.ref_clk(ref_clk), .host_wr(host_wr));

    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // pulse output that belongs to each table entry
    function automatic logic [15:0] pulse_vec(input int i);
        case (i)
            0: return rx_framer_rst_r;
            1: return tx_framer_rst_r;
            2: return rx_link_rst_r;
            3: return tx_link_rst_r;
            4: return rx_es_rst_r;
            5: return tx_es_rst_r;
            6: return bitcode_rst_r;
            default: return integ_restart_r;
        endcase
    endfunction

    // bounded wait for the interrupt pin to reach a level
    task automatic wait_irq(input logic lvl);
        for (int n = 0; n < 8 && irq_n_r !== lvl; n++)
            @(negedge ref_clk);
    endtask

    task automatic report_and_stop;
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ---------------------------------------------
    // tests
    // ---------------------------------------------
    initial
    begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        gric_host_model_inst.zero_port(4'h0);
        chk({15'h0, irq_n_r}, 16'h0001);
        hw_reset_n = 1'b0;
        @(negedge ref_clk);
        chk(dp_reset_r, gric_pkg::PORT_ONES);
        chk({15'h0, test_port_reset_r}, 16'h0000);
        hw_reset_n = 1'b1;
        @(negedge ref_clk);
        test_port_reset_n = 1'b0;
        @(negedge ref_clk);
        chk({15'h0, test_port_reset_r}, 16'h0001);
        chk(dp_reset_r, gric_pkg::PORT_ZERO);
        test_port_reset_n = 1'b1;
        gric_host_model_inst.write_reg(4'h2, gric_pkg::SEL_SOFT_RST_1, 8'h01);
        chk(dp_reset_r, gric_pkg::PORT_ONES);
        gric_host_model_inst.write_reg(4'h9, gric_pkg::SEL_SOFT_RST_2, 8'h80);
        chk(dp_reset_r, gric_pkg::PORT_ONES);
        // each reset bit pulses its own port only; a write without it is silent; code registers pulse on zero data
        for (int i = 0; i < 10; i++)
        begin
            d = (i < 7) ? (8'h01 << bit_tab[i]) : 8'h00;
            gric_host_model_inst.write_reg(4'(i + 3), sel_tab[i], d);
            chk(pulse_vec(i), 16'h0001 << (i + 3));
            @(negedge ref_clk);
            chk(pulse_vec(i), gric_pkg::PORT_ZERO);
            if (i < 7)
            begin
                gric_host_model_inst.write_reg(4'h3, sel_tab[i], ~d);
                chk(pulse_vec(i), gric_pkg::PORT_ZERO);
            end
        end
        gric_host_model_inst.write_reg(4'h6, gric_pkg::SEL_LINE_MAINT, 8'h01);
        chk(tx_power_r, 16'hFFBF);
        chk(line_tx_oe_n_r, gric_pkg::PORT_ONES);
        gric_host_model_inst.write_reg(4'h6, gric_pkg::SEL_LINE_MAINT, 8'h02);
        chk(rx_power_r, 16'hFFBF);
        chk(tx_power_r, gric_pkg::PORT_ONES);
        gric_host_model_inst.enable_line(4'h6);
        chk(line_tx_oe_n_r, 16'hFFBF);
        gric_host_model_inst.write_reg(4'h6, gric_pkg::SEL_LINE_MAINT, 8'h00);
        chk(line_tx_oe_n_r, gric_pkg::PORT_ONES);
        chk(tx_power_r & rx_power_r, gric_pkg::PORT_ONES);
        // group 1 shows alarm 1, group 2 alarm 3
        gpio_alarm = 16'h0802;
        gric_host_model_inst.write_reg(4'h0, gric_pkg::SEL_GPIO_SEL, 8'hB9);
        @(negedge ref_clk);
        chk(gpio_oe_n_r, gric_pkg::PORT_ZERO);
        chk(gpio_out_r, gric_pkg::PORT_ONES);
        gpio_alarm = 16'h0800;
        repeat (2) @(negedge ref_clk);
        chk(gpio_out_r, 16'hFF00);
        // masked event latches silently, unmasking then raises it
        tx_event[42] = 1'b1;
        @(negedge ref_clk);
        tx_event[42] = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk({15'h0, irq_n_r}, 16'h0001);
        chk(tx_irq_info_r, gric_pkg::PORT_ZERO);
        gric_host_model_inst.write_reg(4'h5, gric_pkg::SEL_MASK, 8'h00);
        wait_irq(1'b0);
        chk({15'h0, irq_n_r}, 16'h0000);
        chk(tx_irq_info_r, 16'h0020);
        chk(gfr_info_r, 16'h0020);
        repeat (20) @(negedge ref_clk);
        chk({15'h0, irq_n_r}, 16'h0000);
        gric_host_model_inst.clear_status(4'h5, 8'h04, 8'h00);
        wait_irq(1'b1);
        chk({15'h0, irq_n_r}, 16'h0001);
        chk(tx_irq_info_r | gfr_info_r, gric_pkg::PORT_ZERO);
        // rx and line groups of port 7; bits 7:6 of the byte pick the group
        gric_host_model_inst.write_reg(4'h7, gric_pkg::SEL_MASK, 8'h40);
        gric_host_model_inst.write_reg(4'h7, gric_pkg::SEL_MASK, 8'h80);
        rx_event[56] = 1'b1;
        line_event[56] = 1'b1;
        @(negedge ref_clk);
        rx_event[56] = 1'b0;
        line_event[56] = 1'b0;
        wait_irq(1'b0);
        chk(rx_irq_info_r, 16'h0080);
        chk(gline_info_r, 16'h0080);
        chk(tx_irq_info_r, gric_pkg::PORT_ZERO);
        gric_host_model_inst.write_reg(4'h7, gric_pkg::SEL_STAT_CLR, 8'h41);
        @(negedge ref_clk);
        chk(rx_irq_info_r, gric_pkg::PORT_ZERO);
        chk({gline_info_r[15:1], irq_n_r}, 16'h0080);
        gric_host_model_inst.write_reg(4'h7, gric_pkg::SEL_STAT_CLR, 8'h81);
        wait_irq(1'b1);
        chk({gline_info_r[15:1], irq_n_r}, 16'h0001);
        report_and_stop();
    end

    // hang guard, over thirty times the expected run
    initial
    begin
        #(20 * 5000);
        err_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
